// file: core/pwchk_pkg.sv
// constants for the password validation command handler
package pwchk_pkg;
  // status codes
  localparam logic [7:0] ST_OK       = 8'h00;
  localparam logic [7:0] ST_BAD_IDX  = 8'ha1;
  localparam logic [7:0] ST_PW_FAIL  = 8'hd9;
  localparam logic [7:0] ST_SEC_MEM  = 8'hf9;
  localparam logic [7:0] ST_MEM_ERR  = 8'hee;
  // password index layout
  localparam logic [7:0] IDX_READ_BASE  = 8'h10;
  localparam logic [7:0] IDX_WRITE_BASE = 8'h00;
  localparam int         IDX_SET_LSB    = 0;
  localparam int         IDX_SET_W      = 3;
  localparam logic [2:0] GEN2_LO_SET    = 3'h3;
  localparam logic [2:0] GEN2_HI_SET    = 3'h6;
  // timing
  localparam int CLK_NS          = 100;
  localparam int POR_MS          = 5;
  localparam int POR_TEAR_MS     = 10;
  localparam int WR_MAX_US       = 2000;
  localparam int POR_CYC         = POR_MS * 1000000 / CLK_NS;
  localparam int POR_TEAR_CYC    = POR_TEAR_MS * 1000000 / CLK_NS;
  localparam int WR_CYC          = WR_MAX_US * 1000 / CLK_NS;
  // widths
  localparam int CARD_ID_W = 4;
  localparam int PW_W      = 24;
  localparam int CNT_W     = 4;
  localparam logic [3:0] TRIAL_LIMIT = 4'h8;
endpackage

// file: core/password_check.sv
// password validation command handler with reset and write timing
// Functional notes
// R1 - drop corrupted frames, send nothing
// R2 - status 00 ok, a1 bad index, d9 fail
// R3 - f9 on security memory fault, ee general
// R4 - second generation nacks sets three to six
// R5 - reader: anticollision, zone select, then access
// R6 - reader: security step before zone access
// R7 - zone select before or after security
// R8 - polling reset within 5 or 10 ms
// R9 - eeprom write finishes within 2.0 ms
// R10 - tear-safe writes share one buffer
// R11 - tamper sensors disable all function
// R12 - match 4 bit card identifier
// R13 - pass clears counter, fail increments
// R14 - at trial limit reject all checks
// R15 - keep result until powerdown, exit, new check
// R16 - read 10-17, write 00-07, else unsupported
// R17 - unsupported index skips compare and counter
module password_check #(
  parameter bit GEN2         = 1'b1,
  parameter int POR_CYCLES   = pwchk_pkg::POR_CYC,
  parameter int PORT_CYCLES  = pwchk_pkg::POR_TEAR_CYC,
  parameter int WR_CYCLES    = pwchk_pkg::WR_CYC
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // received command, same clock
  input  wire logic                           cmdValid,
  input  wire logic                           cmdCrcOk,
  input  wire logic [pwchk_pkg::CARD_ID_W-1:0] cmdCardId,
  input  wire logic [7:0]                     cmdIndex,
  input  wire logic [pwchk_pkg::PW_W-1:0]     cmdPassword,
  // state of the tag
  input  wire logic                           activeState,
  input  wire logic [pwchk_pkg::CARD_ID_W-1:0] cardIdentifier,
  input  wire logic                           tearPending,
  // stored password lookup, same clock
  output logic [3:0]                          pwSel,
  input  wire logic [pwchk_pkg::PW_W-1:0]     pwStored,
  input  wire logic                           pwMemFault,
  input  wire logic                           memFault,
  // tamper sensors, asynchronous
  input  wire logic                           tamperVolt,
  input  wire logic                           tamperFreq,
  input  wire logic                           tamperLight,
  // response
  output logic                                rspValid,
  output logic                                rspAck,
  output logic [7:0]                          rspStatus,
  output logic [pwchk_pkg::CARD_ID_W-1:0]     rspCardId,
  // result and status
  output logic                                pwPass,
  output logic [3:0]                          pwActive,
  output logic [pwchk_pkg::CNT_W-1:0]         passwordAttemptCounter,
  output logic                                ready,
  output logic                                disabled,
  // counter write to eeprom via tear-safe buffer
  output logic                                tearSafeWrite,
  output logic                                eeBusy
);

  // ------------------------------------------------------------
  // reset sequencing
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_POR, S_RUN, S_WRITE, S_DEAD} state_t;
  state_t state_r;
  logic [23:0] cnt_r;
  logic        tearSync1_r, tearSync2_r;
  logic [2:0]  tamp1_r, tamp2_r;
  logic        tamper;

  // tear flag synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tearSync1_r <= 1'b0;
      tearSync2_r <= 1'b0;
    end else begin
      tearSync1_r <= tearPending;
      tearSync2_r <= tearSync1_r;
    end
  end

  // tamper sensor synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tamp1_r <= 3'h0;
      tamp2_r <= 3'h0;
    end else begin
      tamp1_r <= {tamperVolt, tamperFreq, tamperLight};
      tamp2_r <= tamp1_r;
    end
  end

  assign tamper = |tamp2_r;

  // decoded command
  logic       idxRead, idxWrite, idxValid, idxGen2Bad, accept, limitHit;
  logic [2:0] idxSet;
  assign idxSet   = cmdIndex[pwchk_pkg::IDX_SET_LSB +: pwchk_pkg::IDX_SET_W];
  assign idxRead  = (cmdIndex & 8'hf8) == pwchk_pkg::IDX_READ_BASE;   // see R16
  assign idxWrite = (cmdIndex & 8'hf8) == pwchk_pkg::IDX_WRITE_BASE;  // see R16
  assign idxGen2Bad = GEN2 && idxSet >= pwchk_pkg::GEN2_LO_SET
                      && idxSet <= pwchk_pkg::GEN2_HI_SET;             // see R4
  assign idxValid = (idxRead || idxWrite) && !idxGen2Bad;
  assign limitHit = passwordAttemptCounter >= pwchk_pkg::TRIAL_LIMIT;
  // corrupted or foreign frames vanish without answer
  assign accept = cmdValid && cmdCrcOk && activeState && state_r == S_RUN && !tamper // see R7
                  && cmdCardId == cardIdentifier;                      // see R1 see R12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_POR;
      cnt_r   <= 24'h0;
    end else begin
      case (state_r)
        S_POR: begin
          cnt_r <= cnt_r + 24'h1;
          if (tamper) begin
            state_r <= S_DEAD;                                         // see R11
          end else if (cnt_r + 24'h1 >= (tearSync2_r ? 24'(PORT_CYCLES)
                                                       : 24'(POR_CYCLES))) begin
            state_r <= S_RUN;                                          // see R8
            cnt_r   <= 24'h0;
          end
        end
        S_RUN: begin
          cnt_r <= 24'h0;
          if (tamper) begin
            state_r <= S_DEAD;                                         // see R11
          end else if (accept && idxValid && !limitHit && !pwMemFault) begin
            state_r <= S_WRITE;
          end
        end
        S_WRITE: begin
          cnt_r <= cnt_r + 24'h1;
          if (tamper) begin
            state_r <= S_DEAD;
          end else if (cnt_r + 24'h1 >= 24'(WR_CYCLES)) begin
            state_r <= S_RUN;                                          // see R9
            cnt_r   <= 24'h0;
          end
        end
        S_DEAD: state_r <= S_DEAD;                                     // see R11
        default: state_r <= S_DEAD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready    <= 1'b0;
      disabled <= 1'b0;
      eeBusy   <= 1'b0;
    end else begin
      ready    <= state_r == S_RUN && !tamper;
      disabled <= state_r == S_DEAD || tamper;
      eeBusy   <= state_r == S_WRITE;
    end
  end

  // ------------------------------------------------------------
  // password check and response
  // ------------------------------------------------------------
  always_comb begin
    pwSel = {cmdIndex[4], idxSet};
  end

  logic match;
  assign match = pwStored == cmdPassword;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid  <= 1'b0;
      rspAck    <= 1'b0;
      rspStatus <= pwchk_pkg::ST_OK;
      rspCardId <= '0;
    end else begin
      rspValid <= 1'b0;
      if (accept) begin
        rspValid  <= 1'b1;
        rspCardId <= cardIdentifier;
        if (!idxValid) begin
          rspAck    <= 1'b0;
          rspStatus <= pwchk_pkg::ST_BAD_IDX;                          // see R17 see R4
        end else if (pwMemFault) begin
          rspAck    <= 1'b0;
          rspStatus <= pwchk_pkg::ST_SEC_MEM;                          // see R3
        end else if (limitHit || !match) begin
          rspAck    <= 1'b0;
          rspStatus <= pwchk_pkg::ST_PW_FAIL;                          // see R2 see R14
        end else begin
          rspAck    <= 1'b1;
          rspStatus <= memFault ? pwchk_pkg::ST_MEM_ERR : pwchk_pkg::ST_OK; // see R2 see R3
        end
      end
    end
  end

  // counter, result and tear-safe staging
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      passwordAttemptCounter <= '0;
      pwPass        <= 1'b0;
      pwActive      <= 4'h0;
      tearSafeWrite <= 1'b0;
    end else begin
      tearSafeWrite <= 1'b0;
      if (!activeState) begin
        pwPass <= 1'b0;                                                // see R15
      end else if (accept) begin
        pwPass <= 1'b0;                                                // see R15
        if (idxValid && !pwMemFault) begin                             // see R17
          pwActive      <= pwSel;                                      // see R15
          tearSafeWrite <= !limitHit;                                  // see R10 see R14
          if (limitHit) begin
            pwPass <= 1'b0;                                            // see R14
          end else if (match) begin
            pwPass                 <= 1'b1;
            passwordAttemptCounter <= '0;                              // see R13
          end else begin
            passwordAttemptCounter <= passwordAttemptCounter + 4'h1;   // see R13
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_NO_RSP_BAD_CRC: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    cmdValid && !cmdCrcOk |=> !rspValid) else $error("response to corrupted frame");
  AST_BAD_IDX: assert property (@(posedge clk) disable iff (!rst_n) // see R17
    accept && !idxValid |=> rspStatus == pwchk_pkg::ST_BAD_IDX && !rspAck
      && $stable(passwordAttemptCounter)) else $error("bad index handling");
  AST_PASS_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // see R13
    accept && idxValid && !pwMemFault && !limitHit && match
      |=> rspAck && passwordAttemptCounter == 0 && pwPass) else $error("pass not cleared");
  AST_FAIL_INC: assert property (@(posedge clk) disable iff (!rst_n) // see R13
    accept && idxValid && !pwMemFault && !limitHit && !match
      |=> rspStatus == pwchk_pkg::ST_PW_FAIL
      && passwordAttemptCounter == $past(passwordAttemptCounter) + 4'h1)
    else $error("fail not counted");
  AST_LIMIT: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    accept && limitHit |=> !rspAck) else $error("check accepted past limit");
  AST_SEC_MEM: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    accept && idxValid && pwMemFault |=> rspStatus == pwchk_pkg::ST_SEC_MEM && !rspAck)
    else $error("security fault status");
  sequence seqShutDown;
    disabled ##1 state_r == S_DEAD;
  endsequence
  AST_TAMPER: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    tamper |=> seqShutDown) else $error("tamper not disabling");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // see R15
    activeState && !accept |=> $stable(pwPass)) else $error("result lost");
  AST_FOREIGN_ID: assert property (@(posedge clk) disable iff (!rst_n) // see R12
    cmdValid && cmdCardId != cardIdentifier |=> !rspValid) else $error("foreign id answered");

  // ------------------------------------------------------------
  // timing and shutdown checks
  // ------------------------------------------------------------
  // cycles spent in power-up and in the current write
  logic [23:0] porLen_r;
  logic [23:0] busyLen_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porLen_r <= 24'h0;
    end else if (state_r == S_POR) begin
      porLen_r <= porLen_r + 24'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyLen_r <= 24'h0;
    end else if (eeBusy) begin
      busyLen_r <= busyLen_r + 24'h1;
    end else begin
      busyLen_r <= 24'h0;
    end
  end

  sequence seqStageWrite;
    tearSafeWrite && !eeBusy ##1 eeBusy;
  endsequence

  AST_POR_TIME: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    state_r == S_POR |-> porLen_r < 24'(PORT_CYCLES)) else $error("power-up too long");
  AST_WRITE_TIME: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    busyLen_r <= 24'(WR_CYCLES)) else $error("write cycle too long");
  AST_WRITE_STAGE: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    accept && idxValid && !pwMemFault && !limitHit |=> seqStageWrite)
    else $error("counter update not staged");
  AST_DEAD_SILENT: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    disabled |-> !rspValid && !tearSafeWrite && !ready) else $error("disabled tag active");
  AST_GEN2_NACK: assert property (@(posedge clk) disable iff (!rst_n) // see R4
    accept && GEN2 && cmdIndex[7:5] == 3'h0 && !cmdIndex[3]
      && cmdIndex[2:0] >= pwchk_pkg::GEN2_LO_SET && cmdIndex[2:0] <= pwchk_pkg::GEN2_HI_SET
      |=> rspValid && !rspAck && rspStatus == pwchk_pkg::ST_BAD_IDX)
    else $error("set not refused");
  AST_ANSWER: assert property (@(posedge clk) disable iff (!rst_n) // see R12
    accept |=> rspValid && rspCardId == $past(cardIdentifier)) else $error("answer missing");
  AST_INACTIVE: assert property (@(posedge clk) disable iff (!rst_n) // see R15
    !activeState |=> !pwPass && !rspValid) else $error("result kept when inactive");
  AST_ONE_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n) // see R15
    accept && idxValid && !pwMemFault |=> pwActive == $past(pwSel))
    else $error("active index not taken");
  AST_LIMIT_FROZEN: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    accept && limitHit |=> !pwPass && !tearSafeWrite && $stable(passwordAttemptCounter))
    else $error("counter moved past limit");

endmodule // password_check

// file: bench/pw_store.sv
// stored password model answering the lookup port
module pw_store (
  // lookup from the handler
  input  wire logic [3:0]  pwSel,
  // stored password back, same cycle
  output logic      [23:0] pwStored
);
  timeunit 1ns;
  timeprecision 1ns;
  // {read bit, set}: read sets 10-17, write sets 00-07, one entry each
  assign pwStored = {20'ha5c3e, pwSel};
endmodule // pw_store

// file: bench/password_check_test.sv
// self-checking bench for the password validation handler
module password_check_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {logic [7:0] idx; logic [4:0] f; logic [7:0] st; logic [3:0] cnt;} row_t;
  logic        clk = 1'b0, rst_n = 1'b0, cmdValid = 1'b0, cmdCrcOk = 1'b0;
  logic [3:0]  cmdCardId = 4'h0, cardIdentifier = 4'h9, pwSel, pwActive, rspCardId, cnt;
  logic [7:0]  cmdIndex = 8'h00, rspStatus;
  logic [23:0] cmdPassword = 24'h000000, pwStored;
  logic        activeState = 1'b1, tearPending = 1'b0, pwMemFault = 1'b0, memFault = 1'b0;
  logic        tamperVolt = 1'b0, tamperFreq = 1'b0, tamperLight = 1'b0;
  logic        rspValid, rspAck, pwPass, ready, disabled, tearSafeWrite, eeBusy;
  int          err_total = 0, checks_done = 0, cycles = 0, rspSeen = 0, wrSeen = 0, got, n;
  int          busySeen = 0, busyLen;
  row_t        rows [9];
  always #50 clk = ~clk;
  password_check #(.POR_CYCLES(20), .PORT_CYCLES(40), .WR_CYCLES(10)) i_password_check (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCrcOk(cmdCrcOk), .cmdCardId(cmdCardId),
    .cmdIndex(cmdIndex), .cmdPassword(cmdPassword), .activeState(activeState),
    .cardIdentifier(cardIdentifier), .tearPending(tearPending), .pwSel(pwSel),
    .pwStored(pwStored), .pwMemFault(pwMemFault), .memFault(memFault),
    .tamperVolt(tamperVolt), .tamperFreq(tamperFreq), .tamperLight(tamperLight),
    .rspValid(rspValid), .rspAck(rspAck), .rspStatus(rspStatus), .rspCardId(rspCardId),
    .pwPass(pwPass), .pwActive(pwActive), .passwordAttemptCounter(cnt), .ready(ready),
    .disabled(disabled), .tearSafeWrite(tearSafeWrite), .eeBusy(eeBusy));
  pw_store i_pw_store (.pwSel(pwSel), .pwStored(pwStored));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rspValid === 1'b1) rspSeen <= rspSeen + 1;
    if (tearSafeWrite === 1'b1) wrSeen <= wrSeen + 1;
    if (eeBusy === 1'b1) busySeen <= busySeen + 1;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(input logic tp, input int lo);
    @(posedge clk) rst_n <= 1'b0;
    tearPending <= tp;
    repeat (20) @(posedge clk);
    #1 check({rspValid, ready, rspStatus, cnt}, 32'h0);
    @(posedge clk) rst_n <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk) n++;
    end
    check(n >= lo && n <= lo + 3, 1);
  endtask
  task automatic send(input logic [7:0] idx, input logic [2:0] g);
    int base, busy0;
    base = rspSeen;
    busy0 = busySeen;
    @(posedge clk) begin
      cmdValid <= 1'b1;
      cmdIndex <= idx;
      cmdCrcOk <= g[1];
      cmdCardId <= g[0] ? cardIdentifier : ~cardIdentifier;
      cmdPassword <= {20'ha5c3e, idx[4], idx[2:0]} ^ {24{~g[2]}};
    end
    @(posedge clk) cmdValid <= 1'b0;
    repeat (3) @(posedge clk);
    n = 0;
    while (eeBusy !== 1'b0 && n < 50) begin
      @(posedge clk) n++;
    end
    #1 got = rspSeen - base;
    busyLen = busySeen - busy0;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rows = '{'{8'h00, 5'b11111, 8'h00, 4'h0}, '{8'h17, 5'b01110, 8'hd9, 4'h1},
      '{8'h03, 5'b11110, 8'ha1, 4'h1}, '{8'h13, 5'b11110, 8'ha1, 4'h1},
      '{8'h08, 5'b11110, 8'ha1, 4'h1}, '{8'h12, 5'b10100, 8'ha1, 4'h1},
      '{8'h12, 5'b11000, 8'ha1, 4'h1}, '{8'h10, 5'b11111, 8'h00, 4'h0},
      '{8'h06, 5'b11110, 8'ha1, 4'h0}};
    do_reset(1'b0, 20);
    for (int i = 0; i < 9; i++) begin
      send(rows[i].idx, rows[i].f[4:2]);
      check(got, rows[i].f[1]);
      check({rspAck, rspStatus, rspCardId}, {rows[i].f[0], rows[i].st, 4'h9});
      check(cnt, rows[i].cnt);
    end
    check(wrSeen > 0, 1);
    send(8'h01, 3'b111);
    check(pwPass, 1'b1);
    check(pwActive, 4'h1);
    check(busyLen, 10);
    @(posedge clk) activeState <= 1'b0;
    send(8'h01, 3'b111);
    check(got, 0);
    check(pwPass, 1'b0);
    @(posedge clk) activeState <= 1'b1;
    memFault <= 1'b1;
    send(8'h11, 3'b111);
    check({rspAck, rspStatus}, 9'h1ee);
    @(posedge clk) memFault <= 1'b0;
    pwMemFault <= 1'b1;
    send(8'h11, 3'b111);
    check({rspAck, rspStatus}, 9'h0f9);
    @(posedge clk) pwMemFault <= 1'b0;
    for (int i = 0; i < 8; i++) send(8'h02, 3'b011);
    check(cnt, 4'h8);
    send(8'h02, 3'b111);
    check(got, 1);
    check({rspAck, rspStatus, cnt}, {1'b0, 8'hd9, 4'h8});
    do_reset(1'b1, 40);
    tamperLight <= 1'b1;
    repeat (5) @(posedge clk);
    send(8'h01, 3'b111);
    check(got, 0);
    check(disabled, 1'b1);
    stop_test();
  end
endmodule // password_check_test
